// File: rtl/nwr_pkg.sv
package nwr_pkg;
    // Clock and bit timing
    localparam int CLK_HZ = 40_000_000;
    localparam int BIT_US = 1920;
    localparam int BIT_CYC = BIT_US * (CLK_HZ / 1_000_000);
    // Tone frequencies in milli-hertz
    localparam longint ZERO_MHZ = 1562500;
    localparam longint ONE_MHZ = 2083300;
    localparam longint TONE_MHZ = 1050000;
    localparam int ZERO_PER = int'(longint'(CLK_HZ) * 1000 / ZERO_MHZ);
    localparam int ONE_PER = int'(longint'(CLK_HZ) * 1000 / ONE_MHZ);
    localparam int TONE_PER = int'(longint'(CLK_HZ) * 1000 / TONE_MHZ);
    // Acceptance windows
    localparam int AFSK_LO_PCT = 75;
    localparam int AFSK_HI_PCT = 125;
    localparam int TONE_TOL_PCT = 1;
    localparam int TONE_MIN_MS = 1000;
    localparam int TONE_PERIODS = int'(TONE_MIN_MS * TONE_MHZ / 1_000_000);
    // Register addresses
    localparam logic [7:0] ADDR_WDATA = 8'hBB;
    localparam logic [7:0] ADDR_MODE = 8'hC1;
    localparam logic [7:0] ADDR_STATUS = 8'hC6;
    localparam logic [7:0] ADDR_MODEM = 8'hC7;
    localparam logic [7:0] ADDR_MASK = 8'hCE;
    // Field positions
    localparam int MODE_NWR_EN = 12;
    localparam int MODE_IN_SEL = 13;
    localparam int MODEM_DATA_EN = 12;
    localparam int STAT_NWR_IRQ = 14;
    localparam int MASK_NWR = 14;
    // Serial frame
    localparam logic [4:0] SER_ADDR_LAST = 5'h07;
    localparam logic [4:0] SER_DATA_LAST = 5'h17;
    localparam logic [4:0] SER_END = 5'h18;
    // Message framing
    localparam logic [7:0] PRE_BYTE = 8'hAB;
    localparam logic [4:0] PRE_BYTES = 5'h10;
    localparam logic [2:0] HDR_LEN = 3'h4;
    localparam logic [31:0] START_CODE = 32'h5A435A43;
    localparam logic [31:0] EOM_CODE = 32'h4E4E4E4E;

    typedef enum {ST_SEARCH, ST_HEADER, ST_DATA} rx_state_t;

    // Weather status/data register layout
    typedef struct packed {
        logic tone;
        logic eom;
        logic start;
        logic [4:0] rsv;
        logic [7:0] data;
    } wdata_t;
endpackage : nwr_pkg

// File: rtl/tone_detect.sv
`timescale 1ns/100ps
module tone_detect #(
    parameter int PER = nwr_pkg::TONE_PER,
    parameter int TOL = nwr_pkg::TONE_PER / 100,
    parameter int NEED = nwr_pkg::TONE_PERIODS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic edge_i,
    output logic tone_o
);
    localparam int CW = $clog2(PER + TOL + 2);
    localparam int GW = $clog2(NEED + 1);
    localparam logic [CW-1:0] LO = CW'(PER - TOL);
    localparam logic [CW-1:0] HI = CW'(PER + TOL);
    localparam logic [CW-1:0] SAT = CW'(PER + TOL + 1);
    logic [CW-1:0] cnt_ff;
    logic [GW-1:0] good_ff;

    // Period counter between rising edges, saturating; the edge cycle
    // counts as one so that a full period reads back as PER
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            cnt_ff <= '0;
        end else if (edge_i) begin
            cnt_ff <= CW'(1);
        end else if (cnt_ff != SAT) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // Count consecutive periods inside the tone window
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            good_ff <= '0;
        end else if (edge_i) begin
            if (cnt_ff >= LO && cnt_ff <= HI) begin
                if (good_ff != GW'(NEED)) begin
                    good_ff <= good_ff + 1'b1;
                end
            end else begin
                good_ff <= '0;
            end
        end else if (cnt_ff == SAT) begin
            good_ff <= '0; // Tone lost
        end
    end

    assign tone_o = (good_ff == GW'(NEED));
endmodule : tone_detect

// File: rtl/fifo2.sv
`timescale 1ns/100ps
module fifo2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [CW-1:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_ff != CW'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rp_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule : fifo2

// File: rtl/weather_alert_decoder.sv
`timescale 1ns/100ps
module weather_alert_decoder #(
    parameter int BIT_CYC_P = nwr_pkg::BIT_CYC,
    parameter int ZERO_PER_P = nwr_pkg::ZERO_PER,
    parameter int ONE_PER_P = nwr_pkg::ONE_PER,
    parameter int TONE_PER_P = nwr_pkg::TONE_PER,
    parameter int TONE_PERIODS_P = nwr_pkg::TONE_PERIODS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sig1_i,
    input wire logic sig2_i,
    input wire logic csn_i,
    input wire logic sclk_i,
    input wire logic cdata_i,
    output logic reply_o,
    output logic irq_n_o
);
    import nwr_pkg::*;

    localparam int PW = $clog2(ZERO_PER_P * AFSK_HI_PCT / 100 + 2);
    localparam int BW = $clog2(BIT_CYC_P);
    localparam logic [PW-1:0] AFSK_MID = PW'((ZERO_PER_P + ONE_PER_P) / 2);
    localparam logic [PW-1:0] AFSK_LO = PW'(ONE_PER_P * AFSK_LO_PCT / 100);
    localparam logic [PW-1:0] AFSK_HI = PW'(ZERO_PER_P * AFSK_HI_PCT / 100);
    localparam logic [PW-1:0] PER_SAT = AFSK_HI + 1'b1;
    localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYC_P - 1);
    localparam logic [BW-1:0] BIT_MID = BW'(BIT_CYC_P / 2);

    // Serial port state
    logic sclk_q_ff;
    logic [4:0] scnt_ff;
    logic [22:0] ssh_ff;
    logic [7:0] addr_ff;
    logic [15:0] rsh_ff;
    logic reply_ff;
    logic irq_n_ff;
    logic s_rise;
    logic s_fall;
    logic addr_done;
    logic wr_done;
    logic [7:0] addr_w;
    logic [15:0] wr_data;
    logic [15:0] stat_w;
    // Control and status
    logic nwr_en_ff;
    logic in_sel_ff;
    logic mask_ff;
    logic data_en_ff;
    logic status_irq_ff;
    wdata_t wd_ff;
    // Demodulator
    logic sig_w;
    logic sig_q_ff;
    logic edge_w;
    logic [PW-1:0] per_ff;
    logic carrier_ff;
    logic demod_ff;
    logic demod_q_ff;
    logic [BW-1:0] ph_ff;
    logic bit_stb;
    logic tone_w;
    logic tone_q_ff;
    // Framing
    rx_state_t state_ff;
    logic [7:0] win_ff;
    logic [2:0] bcnt_ff;
    logic [4:0] pre_ff;
    logic [2:0] hcnt_ff;
    logic [31:0] hdr_ff;
    logic [7:0] nwin;
    logic [2:0] nb;
    logic [31:0] hdr_word;
    logic hdr_skip;
    logic pre_found;
    logic byte_push;
    logic hdr_done;
    logic start_hit;
    logic eom_hit;
    logic irq_evt;
    logic rd_wdata;
    logic rd_status;
    // Byte path
    logic byte_vld_ff;
    logic [7:0] byte_ff;
    logic in_rdy;
    logic out_vld;
    logic [7:0] out_byte;
    logic out_rdy;

    // Serial edge and frame decode
    assign s_rise = sclk_i && !sclk_q_ff && !csn_i;
    assign s_fall = !sclk_i && sclk_q_ff && !csn_i;
    assign addr_done = s_rise && (scnt_ff == SER_ADDR_LAST);
    assign wr_done = s_rise && (scnt_ff == SER_DATA_LAST);
    assign addr_w = {ssh_ff[6:0], cdata_i};
    assign wr_data = {ssh_ff[14:0], cdata_i};
    assign rd_wdata = addr_done && (addr_w == ADDR_WDATA);
    assign rd_status = addr_done && (addr_w == ADDR_STATUS);

    // Status word for reads
    always_comb begin
        stat_w = '0;
        stat_w[STAT_NWR_IRQ] = status_irq_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q_ff <= 1'b0;
        end else begin
            sclk_q_ff <= sclk_i;
        end
    end

    // Shift in address then write data, MSB first
    always_ff @(posedge clk_i) begin
        if (rst_i || csn_i) begin
            scnt_ff <= '0;
            ssh_ff <= '0;
        end else if (s_rise && scnt_ff != SER_END) begin
            ssh_ff <= {ssh_ff[21:0], cdata_i};
            scnt_ff <= scnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_ff <= '0;
        end else if (addr_done) begin
            addr_ff <= addr_w;
        end
    end

    // Read snapshot at address end, shifted out on falling clock
    always_ff @(posedge clk_i) begin
        if (rst_i || csn_i) begin
            rsh_ff <= '0;
            reply_ff <= 1'b0;
        end else if (addr_done) begin
            if (addr_w == ADDR_WDATA) begin
                rsh_ff <= wd_ff;
            end else if (addr_w == ADDR_STATUS) begin
                rsh_ff <= stat_w;
            end else begin
                rsh_ff <= '0;
            end
        end else if (s_fall && scnt_ff > SER_ADDR_LAST) begin
            reply_ff <= rsh_ff[15];
            rsh_ff <= {rsh_ff[14:0], 1'b0};
        end
    end

    // Mode control and interrupt mask writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nwr_en_ff <= 1'b0;
            in_sel_ff <= 1'b0;
            mask_ff <= 1'b0;
        end else if (wr_done) begin
            if (addr_ff == ADDR_MODE) begin
                nwr_en_ff <= wr_data[MODE_NWR_EN];
                in_sel_ff <= wr_data[MODE_IN_SEL];
            end else if (addr_ff == ADDR_MASK) begin
                mask_ff <= wr_data[MASK_NWR];
            end
        end
    end

    // Data-output enable: self-set wins over a host write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_en_ff <= 1'b0;
        end else if (start_hit) begin
            data_en_ff <= 1'b1;
        end else if (wr_done && addr_ff == ADDR_MODEM) begin
            data_en_ff <= wr_data[MODEM_DATA_EN];
        end
    end

    // Input select and rising edges
    assign sig_w = in_sel_ff ? sig2_i : sig1_i;
    assign edge_w = sig_w && !sig_q_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sig_q_ff <= 1'b0;
            tone_q_ff <= 1'b0;
            demod_q_ff <= 1'b0;
        end else begin
            sig_q_ff <= sig_w;
            tone_q_ff <= tone_w;
            demod_q_ff <= demod_ff;
        end
    end

    // Period measure and tone-to-bit decision
    always_ff @(posedge clk_i) begin
        if (rst_i || edge_w) begin
            per_ff <= '0;
        end else if (per_ff != PER_SAT) begin
            per_ff <= per_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carrier_ff <= 1'b0;
            demod_ff <= 1'b0;
        end else if (edge_w) begin
            carrier_ff <= (per_ff >= AFSK_LO) && (per_ff <= AFSK_HI);
            demod_ff <= (per_ff < AFSK_MID);
        end else if (per_ff == PER_SAT) begin
            carrier_ff <= 1'b0;
        end
    end

    // Bit clock recovery, restarted on each bit transition
    always_ff @(posedge clk_i) begin
        if (rst_i || !carrier_ff || demod_ff != demod_q_ff) begin
            ph_ff <= '0;
        end else if (ph_ff == BIT_LAST) begin
            ph_ff <= '0;
        end else begin
            ph_ff <= ph_ff + 1'b1;
        end
    end

    assign bit_stb = carrier_ff && nwr_en_ff && (ph_ff == BIT_MID);

    tone_detect #(
        .PER(TONE_PER_P),
        .TOL(TONE_PER_P * TONE_TOL_PCT / 100),
        .NEED(TONE_PERIODS_P)
    ) u_tone (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(nwr_en_ff),
        .edge_i(edge_w),
        .tone_o(tone_w)
    );

    // Framing events
    assign nwin = {demod_ff, win_ff[7:1]};
    assign nb = bcnt_ff + 1'b1;
    assign hdr_word = {hdr_ff[23:0], nwin};
    assign hdr_skip = (hcnt_ff == '0) && (nwin == PRE_BYTE);
    assign pre_found = bit_stb && state_ff == ST_SEARCH && !data_en_ff
        && nwin == PRE_BYTE && pre_ff == PRE_BYTES - 1'b1;
    assign byte_push = bit_stb && nb == '0
        && ((state_ff == ST_HEADER && !hdr_skip)
        || (state_ff == ST_DATA && data_en_ff));
    assign hdr_done = byte_push && state_ff == ST_HEADER
        && hcnt_ff == HDR_LEN - 1'b1;
    assign start_hit = hdr_done && hdr_word == START_CODE;
    assign eom_hit = hdr_done && hdr_word == EOM_CODE;
    assign irq_evt = pre_found || byte_push || (tone_w && !tone_q_ff);

    // Sync search, header check and data output
    always_ff @(posedge clk_i) begin
        if (rst_i || !nwr_en_ff) begin
            state_ff <= ST_SEARCH;
            win_ff <= '0;
            bcnt_ff <= '0;
            pre_ff <= '0;
            hcnt_ff <= '0;
            hdr_ff <= '0;
        end else begin
            case (state_ff)
                ST_SEARCH: begin
                    if (data_en_ff) begin
                        state_ff <= ST_DATA;
                    end else if (bit_stb) begin
                        win_ff <= nwin;
                        if (nwin == PRE_BYTE) begin
                            bcnt_ff <= '0;
                            if (pre_found) begin
                                state_ff <= ST_HEADER;
                                pre_ff <= '0;
                                hcnt_ff <= '0;
                            end else if (nb == '0 && pre_ff != '0) begin
                                pre_ff <= pre_ff + 1'b1;
                            end else begin
                                pre_ff <= 5'h01;
                            end
                        end else begin
                            bcnt_ff <= nb;
                            if (nb == '0) begin
                                pre_ff <= '0;
                            end
                        end
                    end
                end
                ST_HEADER: begin
                    if (bit_stb) begin
                        win_ff <= nwin;
                        bcnt_ff <= nb;
                        if (nb == '0 && !hdr_skip) begin
                            hdr_ff <= hdr_word;
                            hcnt_ff <= hcnt_ff + 1'b1;
                            if (nwin[7]) begin
                                state_ff <= ST_SEARCH;
                            end else if (hcnt_ff == HDR_LEN - 1'b1) begin
                                // End code or junk re-arms the search
                                state_ff <= start_hit ? ST_DATA : ST_SEARCH;
                            end
                        end
                    end
                end
                default: begin
                    if (!data_en_ff) begin
                        state_ff <= ST_SEARCH;
                        pre_ff <= '0;
                    end else if (bit_stb) begin
                        win_ff <= nwin;
                        bcnt_ff <= nb;
                    end
                end
            endcase
        end
    end

    // Byte holding stage in front of the buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            byte_vld_ff <= 1'b0;
            byte_ff <= '0;
        end else if (byte_push) begin
            byte_vld_ff <= 1'b1;
            byte_ff <= nwin;
        end else if (in_rdy) begin
            byte_vld_ff <= 1'b0;
        end
    end

    // Hold the data field steady while it is being shifted out
    assign out_rdy = !(!csn_i && addr_ff == ADDR_WDATA
        && scnt_ff > SER_ADDR_LAST);

    fifo2 #(
        .W(8),
        .DEPTH(2)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(byte_vld_ff),
        .in_data_i(byte_ff),
        .in_ready_o(in_rdy),
        .out_valid_o(out_vld),
        .out_data_o(out_byte),
        .out_ready_i(out_rdy)
    );

    // Weather status/data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_ff <= '0;
        end else begin
            wd_ff.tone <= tone_w;
            if (start_hit) begin
                wd_ff.start <= 1'b1;
            end else if (rd_wdata) begin
                wd_ff.start <= 1'b0;
            end
            if (eom_hit) begin
                wd_ff.eom <= 1'b1;
            end else if (rd_wdata) begin
                wd_ff.eom <= 1'b0;
            end
            if (out_vld && out_rdy) begin
                wd_ff.data <= out_byte;
            end
        end
    end

    // Interrupt flag: set wins over clear on status read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_irq_ff <= 1'b0;
            irq_n_ff <= 1'b1;
        end else begin
            if (irq_evt && mask_ff) begin
                status_irq_ff <= 1'b1;
            end else if (rd_status) begin
                status_irq_ff <= 1'b0;
            end
            irq_n_ff <= !status_irq_ff;
        end
    end

    assign reply_o = reply_ff;
    assign irq_n_o = irq_n_ff;

    // Checks
    a_tone_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        !nwr_en_ff |=> !tone_w)
        else $error("tone seen while decoder disabled");
    a_pre_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        pre_found && mask_ff |=> status_irq_ff && state_ff == ST_HEADER)
        else $error("preamble did not raise interrupt");
    a_start_auto: assert property (@(posedge clk_i) disable iff (rst_i)
        start_hit |=> data_en_ff && wd_ff.start && state_ff == ST_DATA)
        else $error("start header did not enter data mode");
    a_eom_search: assert property (@(posedge clk_i) disable iff (rst_i)
        eom_hit && !data_en_ff |=> state_ff == ST_SEARCH && !data_en_ff)
        else $error("end header left search mode");
    a_search_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == ST_SEARCH |-> !byte_push)
        else $error("byte output during sync search");
    a_data_leave: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == ST_DATA && !data_en_ff && nwr_en_ff
        |=> state_ff == ST_SEARCH)
        else $error("search not re-armed");
    a_bit7_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        byte_push && state_ff == ST_HEADER && nwin[7] |=> state_ff == ST_SEARCH)
        else $error("eighth bit set accepted in header");
    a_stop_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_done && addr_ff == ADDR_MODEM && !wr_data[MODEM_DATA_EN]
        && !start_hit |=> !data_en_ff)
        else $error("data-output enable not cleared");
    a_phase_range: assert property (@(posedge clk_i) disable iff (rst_i)
        bit_stb |=> !bit_stb [*2])
        else $error("bit strobes too close");
    a_hold_data: assert property (@(posedge clk_i) disable iff (rst_i)
        !out_rdy |=> $stable(wd_ff.data))
        else $error("data changed during read");

    c_preamble: cover property (@(posedge clk_i) disable iff (rst_i) pre_found);
    c_start: cover property (@(posedge clk_i) disable iff (rst_i) start_hit);
    c_eom: cover property (@(posedge clk_i) disable iff (rst_i) eom_hit);
    c_tone: cover property (@(posedge clk_i) disable iff (rst_i) $rose(tone_w));
endmodule : weather_alert_decoder

// File: tb/afsk_source.sv
`timescale 1ns/100ps
module afsk_source #(
    parameter int BIT_P = 192,
    parameter int ZERO_P = 64,
    parameter int ONE_P = 48
) (
    input wire logic clk_i,
    input wire logic sel_i,
    output logic sig1_o,
    output logic sig2_o
);
    logic aud = 1'b0;
    // Audio goes to the chosen input, the other stays quiet
    assign sig1_o = sel_i ? 1'b0 : aud;
    assign sig2_o = sel_i ? aud : 1'b0;
    // Square wave of a given period for a number of cycles
    task automatic play(input int per, input int cyc);
        for (int i = 0; i < cyc; i++) begin
            @(posedge clk_i);
            #1 aud = (i % per) < (per / 2);
        end
    endtask : play
    // Silence after a burst
    task automatic quiet();
        @(posedge clk_i);
        #1 aud = 1'b0;
    endtask : quiet
    // One byte, least significant bit first
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            play(b[i] ? ONE_P : ZERO_P, BIT_P);
        end
    endtask : send_byte
    // Preamble then a four character header
    task automatic burst(input logic [31:0] hdr);
        for (int i = 0; i < 16; i++) begin
            send_byte(nwr_pkg::PRE_BYTE);
        end
        for (int i = 3; i >= 0; i--) begin
            send_byte(hdr[i*8 +: 8]);
        end
    endtask : burst
endmodule : afsk_source

// File: tb/weather_alert_decoder_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module weather_alert_decoder_tb_top;
    import nwr_pkg::*;
    localparam int BIT_P = 192;
    localparam int ZERO_P = 64;
    localparam int ONE_P = 48;
    localparam int TONE_P = 95;
    localparam int TONE_N = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic csn_i = 1'b1;
    logic sclk_i = 1'b0;
    logic cdata_i = 1'b0;
    logic sel = 1'b0;
    logic sig1, sig2, reply_o, irq_n_o;
    int miscompares = 0;
    int num_checks = 0;
    int seed = 14046;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    logic [15:0] got, e, m;
    logic [7:0] rnd;
    event got_ev;
    always #12.5 clk_i = ~clk_i;
    afsk_source #(.BIT_P(BIT_P), .ZERO_P(ZERO_P), .ONE_P(ONE_P)) i_src (
        .clk_i(clk_i), .sel_i(sel), .sig1_o(sig1), .sig2_o(sig2));
    weather_alert_decoder #(.BIT_CYC_P(BIT_P), .ZERO_PER_P(ZERO_P),
        .ONE_PER_P(ONE_P), .TONE_PER_P(TONE_P), .TONE_PERIODS_P(TONE_N)
    ) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .sig1_i(sig1), .sig2_i(sig2),
        .csn_i(csn_i), .sclk_i(sclk_i), .cdata_i(cdata_i),
        .reply_o(reply_o), .irq_n_o(irq_n_o));
    // Verdict and end of run
    task automatic final_report();
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // One serial frame: address and data MSB first, reply kept in got
    task automatic xfer(input logic [7:0] a, input logic [15:0] d);
        logic [23:0] f;
        f = {a, d};
        csn_i = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            cdata_i = f[i];
            sclk_i = 1'b0;
            repeat (2) @(posedge clk_i);
            #1 sclk_i = 1'b1;
            repeat (2) @(posedge clk_i);
            #1 if (i < 16) got[i] = reply_o;
        end
        csn_i = 1'b1;
        sclk_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : xfer
    // Register read with the expected value noted first
    task automatic rd(input logic [7:0] a, input logic [15:0] ev,
                      input logic [15:0] mk);
        exp_q.push_back(ev);
        msk_q.push_back(mk);
        xfer(a, 16'h0000);
        ->got_ev;
    endtask : rd
    // Oldest note against each finished read
    always @(got_ev) begin
        if (exp_q.size() == 0) begin
            miscompares++;
            $display("unexpected at %0t: read with no note", $time);
        end else begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK(got & m, e)
        end
    end
    // Cuts a hang short
    initial begin
        repeat (95000) @(posedge clk_i);
        miscompares++;
        final_report();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        #1 rst_i = 1'b0;
        rd(ADDR_STATUS, 16'h0000, 16'hFFFF);
        `CHK(irq_n_o, 1'b1)
        rd(8'h10, 16'h0000, 16'hFFFF);
        xfer(ADDR_MODE, 16'h1000);
        xfer(ADDR_MASK, 16'h4000);
        rnd = 8'($random(seed)) & 8'h7F;
        i_src.burst(START_CODE);
        i_src.send_byte(rnd);
        i_src.quiet();
        repeat (300) @(posedge clk_i);
        #1 `CHK(irq_n_o, 1'b0)
        rd(ADDR_WDATA, {8'h20, rnd}, 16'hFFFF);
        rd(ADDR_STATUS, 16'h4000, 16'h4000);
        xfer(ADDR_MODEM, 16'h0000);
        xfer(ADDR_MODE, 16'h3000);
        sel = 1'b1;
        i_src.burst(EOM_CODE);
        i_src.quiet();
        repeat (300) @(posedge clk_i);
        #1 rd(ADDR_WDATA, 16'h4000, 16'hE000);
        // Tone bit follows the tone, so read while it still plays
        fork
            i_src.play(TONE_P, TONE_P * (TONE_N + 4));
            begin
                repeat (TONE_P * (TONE_N + 2)) @(posedge clk_i);
                #1 rd(ADDR_WDATA, 16'h8000, 16'h8000);
            end
        join
        i_src.quiet();
        xfer(ADDR_MODEM, 16'h1000);
        xfer(ADDR_MODEM, 16'h0000);
        final_report();
    end
endmodule : weather_alert_decoder_tb_top
